// ===== logic/sotp_params.svh
// constants of the safety output test pulse unit
// assumes inclusion by sotp_pkg, the design files and the bench
`ifndef SOTP_PARAMS_SVH
`define SOTP_PARAMS_SVH

// ==========================================================
// sizes
`define SOTP_NCH 4
`define SOTP_NSIG 16
`define SOTP_SELW 4
`define SOTP_CNTW 16
`define SOTP_ADDRW 8
`define SOTP_STATW 5

// ==========================================================
// register byte offsets
`define SOTP_OFF_SEL 8'h00
`define SOTP_OFF_DIAG 8'h04
`define SOTP_OFF_TOFF 8'h08
`define SOTP_OFF_PER 8'h0C
`define SOTP_OFF_STAT 8'h10
`define SOTP_OFF_MASK 8'h14
`define SOTP_OFF_LIVE 8'h18

// ==========================================================
// reset values and limits
`define SOTP_RST_SEL 16'h0000
`define SOTP_RST_DIAG 4'h0
`define SOTP_RST_TOFF 16'h0040
`define SOTP_RST_PER 16'h1000
`define SOTP_TOFF_MIN 16'h0002
`define SOTP_PER_MIN 16'h0008
`define SOTP_ONE 16'h0001

// ==========================================================
// field positions
`define SOTP_STAT_ALM 4
`define SOTP_HTRANS_ACT 1
`define SOTP_SIG_TORQUE_OFF 0
`define SOTP_SIG_SPEED_MON 7

`endif

// ===== logic/sotp_pkg.sv
// types of the safety output test pulse unit
// assumes sotp_params.svh on the include path
`include "sotp_params.svh"

package sotp_pkg;

  typedef logic [`SOTP_NCH-1:0] sotp_ch_t;

  // terminal readback, one bit per channel and terminal
  typedef struct packed {
    sotp_ch_t a;
    sotp_ch_t b;
  } sotp_pair_t;

  typedef enum logic [1:0] {
    SOTP_HOLD = 2'b00,
    SOTP_RUN = 2'b01,
    SOTP_FORCED = 2'b11
  } sotp_mode_t;

  typedef struct packed {
    sotp_mode_t mode;
    logic [`SOTP_NCH*`SOTP_SELW-1:0] sel;
    sotp_ch_t diag;
    logic [`SOTP_CNTW-1:0] toff;
    logic [`SOTP_CNTW-1:0] per;
    logic [`SOTP_STATW-1:0] stat;
    logic [`SOTP_STATW-1:0] mask;
    logic [`SOTP_CNTW-1:0] cnt;
    logic alm_q;
    logic ph_valid;
    logic ph_write;
    logic [`SOTP_ADDRW-1:0] ph_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic irq;
    logic dev_alarm;
    sotp_ch_t term_a;
    sotp_ch_t term_b;
  } sotp_state_t;

  typedef struct packed {
    logic a_off;
    logic b_off;
  } sotp_chan_st_t;

endpackage

// ===== logic/sotp_chan.sv
// one output channel: off-pulse timing and readback check
// assumes cnt runs 0..per-1 and toff below half the period
`timescale 1ns/1ps
`include "sotp_params.svh"

module sotp_chan
  import sotp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic drive,
  input wire logic diag_en,
  input wire logic [`SOTP_CNTW-1:0] cnt,
  input wire logic [`SOTP_CNTW-1:0] toff,
  input wire logic [`SOTP_CNTW-1:0] half,
  input wire logic rb_a,
  input wire logic rb_b,
  output logic a_off,
  output logic b_off,
  output logic fault
);

  sotp_chan_st_t s;
  sotp_chan_st_t n;
  logic [`SOTP_CNTW-1:0] rel;

  // ==========================================================
  // pulse windows
  always_comb
  begin
    rel = cnt - half;
    // a at the start of the period, b half a period later
    a_off = drive & diag_en & (cnt < toff);
    b_off = drive & diag_en & (cnt >= half) & (rel < toff);
    n.a_off = a_off;
    n.b_off = b_off;
    // first pulse cycle skipped: readback lags the registered pin
    fault = (s.a_off & a_off & (rb_a | ~rb_b))
          | (s.b_off & b_off & (rb_b | ~rb_a));
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else if (clk_en)
      s <= n;
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !clk_en);

  never_both_a: assert property (!(a_off && b_off))
    else $error("both terminals pulsed off together");
  pulse_gated_a: assert property ((a_off || b_off) |-> diag_en && drive)
    else $error("off-pulse without diagnosis enable");
  pulse_width_a: assert property (a_off ##1 (!a_off && drive && diag_en
      && $stable(toff)) |-> $past(cnt) == toff - `SOTP_ONE)
    else $error("off-pulse width differs from setting");
  fault_window_a: assert property (fault |-> s.a_off || s.b_off)
    else $error("fault flagged outside a pulse");

endmodule

// ===== logic/sotp_top.sv
// safety output test pulse unit: four duplicated outputs
// assumes one 200 MHz clock, AHB-Lite single word accesses,
// readback inputs synchronous to clk
//
// Operation
// - parameter picks status signal per channel
// - each channel drives terminals A and B
// - channel four pairs sink and source terminal
// - one signal may feed several channels
// - on channels with diagnosis get off-pulses
// - A and B never pulsed together
// - off-pulse width from off-time setting
// - wiring fault raises output device alarm
// - per channel diagnosis enable, else no pulses
// - outputs off until start-up diagnosis done
// - monitor disabling alarm forces outputs off
// - other alarms leave outputs running
//
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "sotp_params.svh"

module sotp_top
  import sotp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [`SOTP_NSIG-1:0] status_sig,
  input wire logic startup_done,
  input wire logic ssm_disable_alarm,
  input wire sotp_pkg::sotp_pair_t readback,
  output logic [2:0] term_a,
  output logic [2:0] term_b,
  output logic out4_sink_term,
  output logic out4_source_term,
  output logic out_dev_alarm,
  output logic irq
);

  import sotp_pkg::*;

  localparam sotp_state_t RST_STATE = '{
    mode: SOTP_HOLD,
    sel: `SOTP_RST_SEL,
    diag: `SOTP_RST_DIAG,
    toff: `SOTP_RST_TOFF,
    per: `SOTP_RST_PER,
    hreadyout: 1'b1,
    default: '0
  };

  sotp_state_t s;
  sotp_state_t n;
  sotp_ch_t drive;
  sotp_ch_t a_off;
  sotp_ch_t b_off;
  sotp_ch_t fault;
  logic [`SOTP_CNTW-1:0] half;
  logic [`SOTP_CNTW-1:0] toff_eff;
  logic [`SOTP_STATW-1:0] w1c;
  logic [`SOTP_STATW-1:0] set;
  logic accept;

  // ==========================================================
  // functions
  function automatic logic [`SOTP_SELW-1:0] sel_of(
    input logic [`SOTP_NCH*`SOTP_SELW-1:0] sel,
    input int ch
  );
    sel_of = sel[ch*`SOTP_SELW +: `SOTP_SELW];
  endfunction

  function automatic logic hit(
    input logic [`SOTP_ADDRW-1:0] a,
    input logic [`SOTP_ADDRW-1:0] off
  );
    hit = (a == off);
  endfunction

  function automatic logic [`SOTP_CNTW-1:0] at_least(
    input logic [`SOTP_CNTW-1:0] v,
    input logic [`SOTP_CNTW-1:0] lo
  );
    at_least = (v < lo) ? lo : v;
  endfunction

  function automatic logic [31:0] read_reg(
    input sotp_state_t st,
    input logic [`SOTP_ADDRW-1:0] a
  );
    read_reg = 32'h0000_0000;
    if (hit(a, `SOTP_OFF_SEL))
      read_reg = 32'(st.sel);
    if (hit(a, `SOTP_OFF_DIAG))
      read_reg = 32'(st.diag);
    if (hit(a, `SOTP_OFF_TOFF))
      read_reg = 32'(st.toff);
    if (hit(a, `SOTP_OFF_PER))
      read_reg = 32'(st.per);
    if (hit(a, `SOTP_OFF_STAT))
      read_reg = 32'(st.stat);
    if (hit(a, `SOTP_OFF_MASK))
      read_reg = 32'(st.mask);
    if (hit(a, `SOTP_OFF_LIVE))
      read_reg = 32'({st.mode, st.dev_alarm, st.term_b, st.term_a});
  endfunction

  // ==========================================================
  // channels
  assign half = s.per >> 1;
  // keeps the two pulses of a channel apart whatever is written
  assign toff_eff = (s.toff >= half) ? half - `SOTP_ONE : s.toff;

  generate
    for (genvar i = 0; i < `SOTP_NCH; i++)
    begin : g_ch
      // any channel may pick any signal, shared picks allowed
      assign drive[i] = (s.mode == SOTP_RUN)
                      & status_sig[sel_of(s.sel, i)];

      sotp_chan u_chan (
        .clk(clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .drive(drive[i]),
        .diag_en(s.diag[i]),
        .cnt(s.cnt),
        .toff(toff_eff),
        .half(half),
        .rb_a(readback.a[i]),
        .rb_b(readback.b[i]),
        .a_off(a_off[i]),
        .b_off(b_off[i]),
        .fault(fault[i])
      );
    end
  endgenerate

  assign accept = hsel & hready & htrans[`SOTP_HTRANS_ACT];

  // ==========================================================
  // next state
  always_comb
  begin
    n = s;
    w1c = '0;

    // outputs stay off until start-up diagnosis is through
    case (s.mode)
      SOTP_HOLD:
        if (startup_done && !ssm_disable_alarm)
          n.mode = SOTP_RUN;
      SOTP_RUN:
        if (ssm_disable_alarm)
          n.mode = SOTP_FORCED;
      SOTP_FORCED:
        if (!ssm_disable_alarm)
          n.mode = SOTP_RUN;
      default:
        n.mode = SOTP_HOLD;
    endcase

    if (s.cnt >= s.per - `SOTP_ONE)
      n.cnt = '0;
    else
      n.cnt = s.cnt + `SOTP_ONE;

    // same level on both terminals outside off-pulses, channel four as sink and source
    n.term_a = drive & ~a_off;
    n.term_b = drive & ~b_off;

    // register writes in the data phase
    if (s.ph_valid && s.ph_write)
    begin
      if (hit(s.ph_addr, `SOTP_OFF_SEL))
        n.sel = hwdata[`SOTP_NCH*`SOTP_SELW-1:0];
      if (hit(s.ph_addr, `SOTP_OFF_DIAG))
        n.diag = hwdata[`SOTP_NCH-1:0];
      if (hit(s.ph_addr, `SOTP_OFF_TOFF))
        n.toff = at_least(hwdata[`SOTP_CNTW-1:0], `SOTP_TOFF_MIN);
      if (hit(s.ph_addr, `SOTP_OFF_PER))
        n.per = at_least(hwdata[`SOTP_CNTW-1:0], `SOTP_PER_MIN);
      if (hit(s.ph_addr, `SOTP_OFF_STAT))
        w1c = hwdata[`SOTP_STATW-1:0];
      if (hit(s.ph_addr, `SOTP_OFF_MASK))
        n.mask = hwdata[`SOTP_STATW-1:0];
    end

    // a new event beats a clear in the same cycle
    n.alm_q = ssm_disable_alarm;
    set = {ssm_disable_alarm & ~s.alm_q, fault};
    n.stat = (s.stat & ~w1c) | set;
    n.dev_alarm = |n.stat[`SOTP_STATW-2:0];
    n.irq = |(n.stat & n.mask);

    // zero wait states; read sees this cycle's write already
    n.ph_valid = accept;
    n.ph_write = hwrite;
    n.ph_addr = haddr[`SOTP_ADDRW-1:0];
    n.hreadyout = 1'b1;
    if (accept && !hwrite)
      n.hrdata = read_reg(n, haddr[`SOTP_ADDRW-1:0]);
    else
      n.hrdata = 32'h0000_0000;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= RST_STATE;
    else if (clk_en)
      s <= n;
  end

  // ==========================================================
  // outputs
  assign hreadyout = s.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = s.hrdata;
  assign term_a = s.term_a[2:0];
  assign term_b = s.term_b[2:0];
  assign out4_sink_term = s.term_a[`SOTP_NCH-1];
  assign out4_source_term = s.term_b[`SOTP_NCH-1];
  assign out_dev_alarm = s.dev_alarm;
  assign irq = s.irq;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !clk_en);

  hold_all_off_a: assert property (s.mode != SOTP_RUN
      |=> s.term_a == '0 && s.term_b == '0)
    else $error("output driven before start-up done");
  alarm_forces_off_a: assert property ($rose(ssm_disable_alarm)
      |-> ##2 s.term_a == '0 && s.term_b == '0)
    else $error("outputs not off after monitor alarm");
  run_kept_a: assert property (s.mode == SOTP_RUN && !ssm_disable_alarm
      |=> s.mode == SOTP_RUN)
    else $error("run left without disabling alarm");
  sel_follow_a: assert property (s.mode == SOTP_RUN
      && !status_sig[s.sel[`SOTP_SELW-1:0]]
      |=> !s.term_a[0] && !s.term_b[0])
    else $error("channel one ignores its selected signal");
  shared_sel_a: assert property (s.mode == SOTP_RUN
      && sel_of(s.sel, 0) == sel_of(s.sel, 1)
      |-> drive[0] == drive[1])
    else $error("shared selection drives differently");
  dual_term_a: assert property (!s.diag[0]
      |=> s.term_a[0] == s.term_b[0] && s.term_a[0] == $past(drive[0]))
    else $error("terminals A and B of channel one differ");
  ch4_pair_a: assert property (!s.diag[`SOTP_NCH-1]
      |=> out4_sink_term == out4_source_term)
    else $error("channel four sink and source differ");
  fault_alarm_a: assert property (|fault |=> out_dev_alarm
      ##1 irq == |(s.stat & s.mask))
    else $error("wiring fault without device alarm");
  pulse_seen_a: assert property (drive[0] && s.diag[0] && s.cnt == '0
      && $stable(drive[0]) |=> !s.term_a[0])
    else $error("no off-pulse at period start");
  ready_high_a: assert property (hreadyout && !hresp)
    else $error("slave stalled or signalled error");

  pulse_run_c: cover property (s.diag[0] ##1 $fell(s.term_a[0])
      ##[1:300] $rose(s.term_a[0]));
  fault_c: cover property (|fault ##1 out_dev_alarm);
  forced_c: cover property (s.mode == SOTP_RUN ##1 s.mode == SOTP_FORCED);
  irq_c: cover property ($rose(irq));

endmodule

// ===== test/sotp_load.sv
// load model on the four duplicated outputs: terminal readback
// assumes terminals on = 1 and readback with no delay
`timescale 1ns/1ps

module sotp_load
  import sotp_pkg::*;
(
  input wire logic [3:0] term_a4,
  input wire logic [3:0] term_b4,
  input wire logic [3:0] stuck_a,
  output sotp_pkg::sotp_pair_t readback
);
  // ==========================================================
  // readback
  // stuck_a models an A wire shorted to supply, seen only in a pulse
  assign readback = {term_a4 | stuck_a, term_b4};
endmodule

// ===== test/safety_output_test_pulse_unit_tb.sv
// bench for the safety output test pulse unit
// assumes sotp_top and the load model sotp_load beside it
`timescale 1ns/1ps
`include "sotp_params.svh"

module safety_output_test_pulse_unit_tb;
  import sotp_pkg::*;
  // ==========================================================
  // signals
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, startup_done = 0;
  logic ssm_disable_alarm = 0, clk_en = 1;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [15:0] status_sig = 0, sel;
  logic [3:0] stuck_a = 0;
  logic hreadyout, hresp, irq, out_dev_alarm, o4_sink, o4_src;
  logic [2:0] term_a, term_b;
  sotp_pair_t readback;
  wire [3:0] ta = {o4_sink, term_a};
  wire [3:0] tbv = {o4_src, term_b};
  int n_mismatch = 0, checked = 0, cyc = 0, la[4], lb[4], lab[4];
  logic [31:0] rst_tab [8] = '{32'h0, 32'h0, 32'h40, 32'h1000,
                               32'h0, 32'h0, 32'h0, 32'h0};

  always #2.5 clk = ~clk;

  sotp_top u_sotp_top (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .status_sig(status_sig), .startup_done(startup_done),
    .ssm_disable_alarm(ssm_disable_alarm), .readback(readback),
    .term_a(term_a), .term_b(term_b), .out4_sink_term(o4_sink),
    .out4_source_term(o4_src), .out_dev_alarm(out_dev_alarm),
    .irq(irq));

  sotp_load u_sotp_load (.term_a4(ta), .term_b4(tbv),
    .stuck_a(stuck_a), .readback(readback));

  // ==========================================================
  // helpers
  function automatic logic [3:0] e4(input logic [15:0] s,
                                    input logic [15:0] sig);
    for (int i = 0; i < 4; i++)
      e4[i] = sig[s[4*i+:4]];
  endfunction

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // single word transfer; hrdata taken as it stood at the data edge
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    r = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(nm, e, r);
  endtask

  // two whole periods, so the low counts do not depend on phase
  task count_low;
    la = '{0, 0, 0, 0};
    lb = '{0, 0, 0, 0};
    lab = '{0, 0, 0, 0};
    repeat (32)
    begin
      @(negedge clk);
      for (int i = 0; i < 4; i++)
      begin
        la[i] += int'(!ta[i]);
        lb[i] += int'(!tbv[i]);
        lab[i] += int'(!ta[i] && !tbv[i]);
      end
    end
    @(posedge clk);
  endtask

  task done(input string nm);
    $display("test %s finished, %0d checks so far", nm, checked);
  endtask

  task tally_and_finish;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_mismatch++;
      tally_and_finish;
    end
  end

  // ==========================================================
  // tests
  initial
  begin
    void'($urandom(32'ha341));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++)
      rd_chk("reset reg", 8'(4 * i), rst_tab[i]);
    status_sig <= 16'($urandom);
    repeat (6) @(posedge clk);
    #1 chk("held off", 32'h0, {24'h0, tbv, ta});
    done("reset");
    startup_done <= 1'b1;
    for (int k = 0; k < 12; k++)
    begin
      sel = (k == 0) ? 16'h7777 : 16'($urandom);
      wr(`SOTP_OFF_SEL, {16'h0, sel});
      status_sig <= 16'($urandom);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("terms", {24'h0, e4(sel, status_sig), e4(sel, status_sig)},
          {24'h0, tbv, ta});
      @(posedge clk);
    end
    done("select");
    status_sig <= 16'hffff;
    wr(`SOTP_OFF_TOFF, 32'h1);
    rd_chk("toff floor", `SOTP_OFF_TOFF, 32'h2);
    wr(`SOTP_OFF_PER, 32'h10);
    wr(`SOTP_OFF_TOFF, 32'h3);
    wr(`SOTP_OFF_DIAG, 32'hb);
    wr(`SOTP_OFF_MASK, 32'h1f);
    repeat (20) @(posedge clk);
    count_low;
    for (int i = 0; i < 4; i++)
    begin
      chk("a low", (i == 2) ? 32'h0 : 32'h6, la[i]);
      chk("b low", (i == 2) ? 32'h0 : 32'h6, lb[i]);
      chk("both low", 32'h0, lab[i]);
    end
    rd_chk("no fault", `SOTP_OFF_STAT, 32'h0);
    done("pulses");
    stuck_a <= 4'h1;
    repeat (40) @(posedge clk);
    rd_chk("fault stat", `SOTP_OFF_STAT, 32'h1);
    chk("dev alarm", 32'h1, {31'h0, out_dev_alarm});
    chk("irq on", 32'h1, {31'h0, irq});
    wr(`SOTP_OFF_MASK, 32'h0);
    repeat (2) @(posedge clk);
    #1 chk("irq masked", 32'h0, {31'h0, irq});
    stuck_a <= 4'h0;
    repeat (40) @(posedge clk);
    wr(`SOTP_OFF_STAT, 32'h1f);
    rd_chk("stat clear", `SOTP_OFF_STAT, 32'h0);
    chk("alarm clear", 32'h0, {31'h0, out_dev_alarm});
    done("fault");
    wr(`SOTP_OFF_DIAG, 32'h0);
    ssm_disable_alarm <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("forced off", 32'h0, {24'h0, tbv, ta});
    @(posedge clk);
    rd_chk("alarm stat", `SOTP_OFF_STAT, 32'h10);
    rd_chk("live forced", `SOTP_OFF_LIVE, 32'h0000_0600);
    clk_en <= 1'b0;
    ssm_disable_alarm <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("frozen", 32'h0, {24'h0, tbv, ta});
    @(posedge clk);
    clk_en <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("resumed", 32'hff, {24'h0, tbv, ta});
    done("alarm");
    tally_and_finish;
  end
endmodule
